// ### mac_regs.vh
// timing constants and field layout for the converter host controller
`ifndef MAC_REGS_VH
`define MAC_REGS_VH
`define MAC_CLK_NS 100
`define MAC_RDONLY_WAIT_NS 655
`define MAC_RDONLY_WAIT_CYC ((`MAC_RDONLY_WAIT_NS + `MAC_CLK_NS - 1) / `MAC_CLK_NS)
`define MAC_RD_GAP_NS 50
`define MAC_RD_GAP_CYC ((`MAC_RD_GAP_NS + `MAC_CLK_NS - 1) / `MAC_CLK_NS)
`define MAC_PIPE_MIN_NS 200
`define MAC_PIPE_MAX_NS 400
`define MAC_PIPE_RD_CYC ((`MAC_PIPE_MIN_NS + `MAC_CLK_NS - 1) / `MAC_CLK_NS)
`define MAC_WR_PULSE_NS 100
`define MAC_WR_PULSE_CYC ((`MAC_WR_PULSE_NS + `MAC_CLK_NS - 1) / `MAC_CLK_NS)
`define MAC_EOC_MAX_NS 520
`define MAC_EOC_MAX_CYC ((`MAC_EOC_MAX_NS + `MAC_CLK_NS - 1) / `MAC_CLK_NS)
`define MAC_FAST_RD_NS 350
`define MAC_FAST_RD_CYC ((`MAC_FAST_RD_NS + `MAC_CLK_NS - 1) / `MAC_CLK_NS)
`define MAC_RD_ACC_NS 100
`define MAC_RD_ACC_CYC ((`MAC_RD_ACC_NS + `MAC_CLK_NS - 1) / `MAC_CLK_NS)
`define MAC_PIPE_DISCARD 2
`define MAC_CNT_W 4
`define MAC_DATA_W 8
`define MAC_FIFO_DEPTH 32
`define MAC_FIFO_AW 5
`define MAC_MODE_RD 2'h0
`define MAC_MODE_PIPE 2'h1
`define MAC_MODE_WRRD 2'h2
`endif

// ### mac_ctrl.v
// host controller that runs the multi-step converter and buffers results
// Contract
// R1 - device makes result in two flashes
// R2 - device turns thermometer into range code
// R3 - device corrects estimate down on overlap
// R4 - device corrects estimate errors to sixteen steps
// R5 - device decodes estimate with flash bits
// R6 - device flash outputs are thermometer coded
// R7 - mode pin low read, high write-read
// R8 - hold read low until data appears
// R9 - device drives done low at end
// R10 - host waits gap before next read
// R11 - device busy flag low during conversion
// R12 - first dual-channel result channel unknown
// R13 - pipelined read pulse 200 to 400 ns
// R14 - pipelined read returns previous result
// R15 - first two pipelined reads are undefined
// R16 - write falling edge starts conversion
// R17 - done low within 520 ns after write
// R18 - host may read 350 ns after write
// R19 - early read forces done and data
// R20 - fast write-read repeats every 660 ns; host repeats every 1100 ns (11 clocks)
// R21 - channel switches only after current conversion
// R22 - device drives bus only during read
`include "mac_regs.vh"
`default_nettype none
module mac_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_in, // clock
	input wire rst_in, // sync reset
	input wire [WIDTH-1:0] wdata_in, // write word
	input wire wvalid_in, // write valid
	output wire wready_out, // not full
	output wire [WIDTH-1:0] rdata_out, // head word
	output wire rvalid_out, // not empty
	input wire rready_in // pop
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wp_ff;
	reg [AW-1:0] rp_ff;
	reg [AW:0] cnt_ff;
	wire push;
	wire pop;
	assign wready_out = (cnt_ff != DEPTH[AW:0]);
	assign rvalid_out = (cnt_ff != {(AW+1){1'b0}});
	assign push = wvalid_in & wready_out;
	assign pop = rready_in & rvalid_out;
	assign rdata_out = mem_ff[rp_ff];
	always @(posedge clk_in) begin
		if (push) begin
			mem_ff[wp_ff] <= wdata_in;
		end
	end
	always @(posedge clk_in) begin
		if (rst_in) begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (pop) begin
				rp_ff <= rp_ff + 1'b1;
			end
			if (push & ~pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop & ~push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule

module mac_ctrl (
	input wire CLK_IN, // 10 MHz clock
	input wire RST_IN, // sync reset, high
	input wire START_IN, // request one conversion
	input wire [1:0] MODE_SEL_IN, // 0 read, 1 pipelined, 2 write-read
	input wire CHAN_IN, // channel address wanted
	input wire FAST_IN, // write-read: read without waiting for done
	output reg BUSY_OUT, // sequence in progress
	output reg CS_N_OUT, // chip select, low
	output reg RD_N_OUT, // read strobe, low
	output reg WR_N_OUT, // write strobe, low
	output reg MODE_PIN_OUT, // converter mode pin
	output reg CHANNEL_ADDRESS_OUT, // multiplexer address
	input wire [7:0] RESULT_BUS_IN, // converter data bus
	input wire DONE_N_IN, // end of conversion, low
	input wire RDY_IN, // open-drain ready level
	output reg RDY_OE_OUT, // never drives ready, always low
	output reg [8:0] RES_DATA_OUT, // {channel, result}
	output reg RES_VALID_OUT, // result available
	input wire RES_READY_IN // result taken
);
	localparam S_IDLE = 6'h01;
	localparam S_RDLOW = 6'h02;
	localparam S_WRLOW = 6'h04;
	localparam S_WAIT = 6'h08;
	localparam S_RDACC = 6'h10;
	localparam S_GAP = 6'h20;
	reg [5:0] st_ff;
	reg [5:0] nxt_st;
	reg [`MAC_CNT_W-1:0] cnt_ff;
	reg [`MAC_CNT_W-1:0] nxt_cnt;
	reg [1:0] mode_ff;
	reg [1:0] pipe_seen_ff;
	reg chan_ff;
	reg chan_prev_ff;
	reg first_ff;
	reg push_ff;
	reg [8:0] push_data_ff;
	wire fifo_ready;
	wire fifo_vld;
	wire [8:0] fifo_data;
	wire fifo_pop;
	// cycle counts are small; only the counter's low bits are kept
	localparam C_WAIT_I = `MAC_RDONLY_WAIT_CYC;
	localparam C_GAP_I = `MAC_RD_GAP_CYC;
	localparam C_PIPE_I = `MAC_PIPE_RD_CYC;
	localparam C_WR_I = `MAC_WR_PULSE_CYC;
	localparam C_EOC_I = `MAC_EOC_MAX_CYC;
	localparam C_FAST_I = `MAC_FAST_RD_CYC;
	localparam C_ACC_I = `MAC_RD_ACC_CYC;
	wire [`MAC_CNT_W-1:0] c_wait = C_WAIT_I[`MAC_CNT_W-1:0];
	wire [`MAC_CNT_W-1:0] c_gap = C_GAP_I[`MAC_CNT_W-1:0];
	wire [`MAC_CNT_W-1:0] c_pipe = C_PIPE_I[`MAC_CNT_W-1:0];
	wire [`MAC_CNT_W-1:0] c_wr = C_WR_I[`MAC_CNT_W-1:0];
	wire [`MAC_CNT_W-1:0] c_eoc = C_EOC_I[`MAC_CNT_W-1:0];
	wire [`MAC_CNT_W-1:0] c_fast = C_FAST_I[`MAC_CNT_W-1:0];
	wire [`MAC_CNT_W-1:0] c_acc = C_ACC_I[`MAC_CNT_W-1:0];
	assign fifo_pop = fifo_vld && (!RES_VALID_OUT || RES_READY_IN);
	wire cnt_done = (cnt_ff == {`MAC_CNT_W{1'b0}});

	always @* begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		if (!cnt_done) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
		case (st_ff)
		S_IDLE: begin
			// stall while the result buffer is full
			if (START_IN && fifo_ready) begin
				if (MODE_SEL_IN == `MAC_MODE_WRRD) begin
					// R16 write edge starts
					nxt_st = S_WRLOW;
					nxt_cnt = c_wr;
				end else begin
					nxt_st = S_RDLOW;
					// R13 pipelined pulse width
					nxt_cnt = (MODE_SEL_IN == `MAC_MODE_PIPE) ? c_pipe : c_wait;
				end
			end
		end
		S_RDLOW: begin
			// R8 hold read until data
			// R11 ready high acknowledges transfer
			if (cnt_done && (mode_ff == `MAC_MODE_PIPE ||
				(!DONE_N_IN && RDY_IN))) begin
				nxt_st = S_GAP;
				nxt_cnt = c_gap;
			end
		end
		S_WRLOW: begin
			if (cnt_done) begin
				nxt_st = S_WAIT;
				// R18 early read option
				nxt_cnt = FAST_IN ? c_fast - 1'b1 : c_eoc;
			end
		end
		S_WAIT: begin
			// R17 done bounded wait
			if (cnt_done || (!FAST_IN && !DONE_N_IN)) begin
				nxt_st = S_RDACC;
				nxt_cnt = c_acc;
			end
		end
		S_RDACC: begin
			// R19 early read yields data
			// R20 fast path read access
			if (cnt_done) begin
				nxt_st = S_GAP;
				nxt_cnt = c_gap;
			end
		end
		S_GAP: begin
			// R10 spacing between reads
			if (cnt_done) begin
				nxt_st = S_IDLE;
			end
		end
		default: begin
			nxt_st = S_IDLE;
		end
		endcase
	end

	wire capture = ((st_ff == S_RDLOW) || (st_ff == S_RDACC)) &&
		(nxt_st == S_GAP);

	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			st_ff <= S_IDLE;
			cnt_ff <= {`MAC_CNT_W{1'b0}};
			mode_ff <= `MAC_MODE_RD;
			pipe_seen_ff <= 2'h0;
			chan_ff <= 1'b0;
			chan_prev_ff <= 1'b0;
			first_ff <= 1'b1;
			push_ff <= 1'b0;
			push_data_ff <= 9'h000;
			BUSY_OUT <= 1'b0;
			CS_N_OUT <= 1'b1;
			RD_N_OUT <= 1'b1;
			WR_N_OUT <= 1'b1;
			MODE_PIN_OUT <= 1'b0;
			CHANNEL_ADDRESS_OUT <= 1'b0;
			RDY_OE_OUT <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			push_ff <= 1'b0;
			RDY_OE_OUT <= 1'b0;
			BUSY_OUT <= (nxt_st != S_IDLE);
			if (st_ff == S_IDLE && nxt_st != S_IDLE) begin
				mode_ff <= MODE_SEL_IN;
				// R7 mode pin level
				MODE_PIN_OUT <= (MODE_SEL_IN == `MAC_MODE_WRRD);
				chan_prev_ff <= chan_ff;
				chan_ff <= CHAN_IN;
				CHANNEL_ADDRESS_OUT <= CHAN_IN;
			end
			CS_N_OUT <= (nxt_st == S_IDLE) || (nxt_st == S_GAP);
			RD_N_OUT <= !((nxt_st == S_RDLOW) || (nxt_st == S_RDACC));
			WR_N_OUT <= !(nxt_st == S_WRLOW);
			if (capture) begin
				first_ff <= 1'b0;
				if (mode_ff == `MAC_MODE_PIPE) begin
					// R15 drop first two reads
					if (pipe_seen_ff != `MAC_PIPE_DISCARD) begin
						pipe_seen_ff <= pipe_seen_ff + 1'b1;
					end else begin
						push_ff <= 1'b1;
					end
					// R14 data is previous conversion
					push_data_ff <= {chan_prev_ff, RESULT_BUS_IN};
				end else begin
					// R12 first result channel unknown, dropped
					push_ff <= !first_ff;
					push_data_ff <= {chan_ff, RESULT_BUS_IN};
				end
			end
		end
	end

	// result ports on flops; this stage adds one word of room
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			RES_VALID_OUT <= 1'b0;
			RES_DATA_OUT <= 9'h000;
		end else if (fifo_pop) begin
			RES_VALID_OUT <= 1'b1;
			RES_DATA_OUT <= fifo_data;
		end else if (RES_READY_IN) begin
			RES_VALID_OUT <= 1'b0;
		end
	end

	mac_fifo #(
		.WIDTH(9),
		.DEPTH(`MAC_FIFO_DEPTH),
		.AW(`MAC_FIFO_AW)
	) u_fifo (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.wdata_in(push_data_ff),
		.wvalid_in(push_ff),
		.wready_out(fifo_ready),
		.rdata_out(fifo_data),
		.rvalid_out(fifo_vld),
		.rready_in(fifo_pop)
	);
endmodule
`default_nettype wire

// ### mac_ctrl_sva.sv
// strobe checker for the converter host controller
`default_nettype none
module mac_ctrl_sva (
	input wire logic CLK_IN, // clock
	input wire logic RST_IN, // reset
	input wire logic BUSY_OUT, // busy
	input wire logic CS_N_OUT, // select
	input wire logic RD_N_OUT, // read
	input wire logic WR_N_OUT, // write
	input wire logic MODE_PIN_OUT, // mode pin
	input wire logic RDY_OE_OUT // ready enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence seq_wr_pulse;
		!WR_N_OUT [*2] ##1 WR_N_OUT;
	endsequence
	sequence seq_rd_min;
		!RD_N_OUT [*2];
	endsequence
	AST_RESET: assert property ($fell(RST_IN) |->
		CS_N_OUT && RD_N_OUT && WR_N_OUT && !BUSY_OUT) else $error("bad reset");
	AST_RD_IN_CS: assert property (!RD_N_OUT |-> !CS_N_OUT && BUSY_OUT)
		else $error("read without select");
	AST_WR_MODE: assert property (!WR_N_OUT |-> MODE_PIN_OUT && !CS_N_OUT)
		else $error("write outside write-read mode");
	AST_WR_PULSE: assert property ($fell(WR_N_OUT) |-> seq_wr_pulse)
		else $error("write pulse width");
	AST_RD_WIDTH: assert property ($fell(RD_N_OUT) |-> seq_rd_min)
		else $error("read pulse too short");
	AST_RD_GAP: assert property ($rose(RD_N_OUT) |-> RD_N_OUT [*2])
		else $error("read gap too short");
	AST_EOC_BOUND: assert property ($rose(WR_N_OUT) |-> ##[1:8] !RD_N_OUT)
		else $error("read late after write");
	AST_FAST_READ: assert property ($rose(WR_N_OUT) |-> RD_N_OUT [*3])
		else $error("read too early after write");
	AST_RDY_OE: assert property (RDY_OE_OUT == 1'b0)
		else $error("ready pin driven");
endmodule
bind mac_ctrl mac_ctrl_sva u_sva (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.BUSY_OUT(BUSY_OUT), .CS_N_OUT(CS_N_OUT), .RD_N_OUT(RD_N_OUT),
	.WR_N_OUT(WR_N_OUT), .MODE_PIN_OUT(MODE_PIN_OUT),
	.RDY_OE_OUT(RDY_OE_OUT));
`default_nettype wire

// ### mac_adc_model.sv
// behavioural model of the multi-step converter's digital side
`default_nettype none
module mac_adc_model (
	input wire logic clk_in, // clock
	input wire logic rst_in, // power-up
	input wire logic cs_n_in, // select
	input wire logic rd_n_in, // read
	input wire logic wr_n_in, // write
	input wire logic mode_in, // mode pin
	input wire logic addr_in, // channel
	output logic [7:0] data_out, // result bus
	output logic done_n_out, // end of conversion
	output logic rdy_out // ready, open drain
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] k;
	logic [2:0] t;
	logic [7:0] cur, prev, last;
	logic rd_q, wr_q;
	// released bus shows inverse of last value
	assign data_out = (!cs_n_in && !rd_n_in) ?
		((mode_in || t == 0) ? cur : prev) : ~last;
	assign rdy_out = (t == 0);
	always @(posedge clk_in) begin
		rd_q <= rd_n_in;
		wr_q <= wr_n_in;
		if (!cs_n_in && !rd_n_in)
			last <= data_out;
		if (rst_in) begin
			k <= 5'h0;
			t <= 3'h0;
			done_n_out <= 1'b1;
			cur <= 8'hA5;
			last <= 8'h00;
		end else if ((!mode_in && rd_q && !rd_n_in) ||
			(mode_in && wr_q && !wr_n_in)) begin
			prev <= cur;
			cur <= {addr_in, 2'h0, k};
			k <= k + 5'h1;
			t <= 3'h5;
			done_n_out <= 1'b1;
		end else begin
			if (t != 0)
				t <= t - 3'h1;
			// done at end or forced by read
			if (t == 1 || (mode_in && !rd_n_in))
				done_n_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### mac_ctrl_test.sv
// self-checking bench for the converter host controller
`default_nettype none
module mac_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, start = 0, chan = 0, fast = 0, rdy = 0;
	logic [1:0] mode = 2'h0;
	logic busy, cs_n, rd_n, wr_n, mpin, addr, oe, done_n, rdy_m, vld;
	logic [7:0] bus;
	logic [8:0] rdata;
	int failures = 0, num_checks = 0, cyc = 0, n;
	mac_ctrl uut (.CLK_IN(clk), .RST_IN(rst), .START_IN(start),
		.MODE_SEL_IN(mode), .CHAN_IN(chan), .FAST_IN(fast), .BUSY_OUT(busy),
		.CS_N_OUT(cs_n), .RD_N_OUT(rd_n), .WR_N_OUT(wr_n), .MODE_PIN_OUT(mpin),
		.CHANNEL_ADDRESS_OUT(addr), .RESULT_BUS_IN(bus), .DONE_N_IN(done_n),
		.RDY_IN(rdy_m && !oe), .RDY_OE_OUT(oe), .RES_DATA_OUT(rdata),
		.RES_VALID_OUT(vld), .RES_READY_IN(rdy));
	mac_adc_model dev (.clk_in(clk), .rst_in(rst), .cs_n_in(cs_n),
		.rd_n_in(rd_n), .wr_n_in(wr_n), .mode_in(mpin), .addr_in(addr),
		.data_out(bus), .done_n_out(done_n), .rdy_out(rdy_m));
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			stop_test;
		end
	end
	task automatic chk(input logic [8:0] e, g, input string nm);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// reset, then hold start until k sequences began or time runs out
	task automatic run(input logic [1:0] m, input logic c, f, input int k);
		logic b;
		b = 0;
		n = 0;
		rst <= 1;
		repeat (6) @(posedge clk);
		rst <= 0;
		mode <= m;
		chan <= c;
		fast <= f;
		start <= 1;
		repeat (1500) begin
			@(posedge clk);
			#1;
			if (busy && !b)
				n++;
			b = busy;
			if (n == k)
				break;
		end
		@(posedge clk) start <= 0;
	endtask
	task automatic pop(input logic [8:0] e);
		int w;
		w = 0;
		do begin
			@(negedge clk);
			w++;
		end while (vld !== 1'b1 && w < 200);
		chk(9'h001, {8'h00, vld}, "valid");
		chk(e, rdata, "result");
		@(posedge clk) rdy <= 1;
		@(posedge clk) rdy <= 0;
	endtask
	task automatic t_read;
		run(2'h0, 1'b1, 1'b0, 3);
		pop(9'h181);
		pop(9'h182);
	endtask
	task automatic t_pipe;
		run(2'h1, 1'b0, 1'b0, 4);
		pop(9'h001);
		pop(9'h002);
	endtask
	task automatic t_wrrd;
		run(2'h2, 1'b1, 1'b0, 2);
		pop(9'h181);
		run(2'h2, 1'b1, 1'b1, 2);
		pop(9'h181);
	endtask
	// buffer full refuses starts; drained words keep order
	task automatic t_fill;
		run(2'h0, 1'b0, 1'b0, 99);
		chk(9'd34, 9'(n), "sequences");
		for (int i = 1; i <= 33; i++)
			pop(9'(i % 32));
	endtask
	task automatic stop_test;
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		t_read;
		t_pipe;
		t_wrrd;
		t_fill;
		stop_test;
	end
endmodule
`default_nettype wire
